// ==== gpio_direction_and_data_regs.sv ====
// Direction registers of ports A, B and C and data register of port C.
//
// Function
// - Set port A direction bit drives pin.
// - Cleared direction bit makes pin an input.
// - External data bus select disables port A direction.
// - Port A bits govern pins only as GPIO.
// - Reset clears all direction and data bits.
// - Port B direction bits 5:0, rest zero.
// - Port B bits govern pins only as GPIO.
// - Written port C data drives output pins.
// - Output bits read back last written value.
// - Input bits read the pin level through a two-stage synchroniser.
// - Port C data bits 7:0, rest zero.
// - Port C direction holds eight bits.
module gpio_direction_and_data_regs #(
    parameter int PORT_A_PINS = gpio_regs_pkg::PORT_A_WIDTH,
    parameter int PORT_B_PINS = gpio_regs_pkg::PORT_B_WIDTH,
    parameter int PORT_C_PINS = gpio_regs_pkg::PORT_C_WIDTH
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // APB slave.
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Function selects from the pin multiplexer.
    input  wire logic                   extBusDataSelect,
    input  wire logic [PORT_B_PINS-1:0] portBGpioSelect,
    // Output values of ports A and B from their data registers.
    input  wire logic [PORT_A_PINS-1:0] portAValue,
    input  wire logic [PORT_B_PINS-1:0] portBValue,
    // Pin drivers; an enable low means the pin is driven.
    output logic      [PORT_A_PINS-1:0] portAPinOut,
    output logic      [PORT_A_PINS-1:0] portAPinOeLow,
    output logic      [PORT_B_PINS-1:0] portBPinOut,
    output logic      [PORT_B_PINS-1:0] portBPinOeLow,
    input  wire logic [PORT_C_PINS-1:0] portCPinIn,
    output logic      [PORT_C_PINS-1:0] portCPinOut,
    output logic      [PORT_C_PINS-1:0] portCPinOeLow,
    // Register contents for the rest of the GPIO unit.
    output logic      [PORT_A_PINS-1:0] portAPinDirection,
    output logic      [PORT_B_PINS-1:0] portBPinDirection,
    output logic      [PORT_C_PINS-1:0] portCPinDirection
);

    // Reset release through two flip-flops.
    logic                   rstMeta;
    logic                   rstSyncN;

    // Stored register fields.
    logic [PORT_A_PINS-1:0] dirA;
    logic [PORT_B_PINS-1:0] dirB;
    logic [PORT_C_PINS-1:0] dirC;
    logic [PORT_C_PINS-1:0] valueC;

    // Next register values taken from the write data.
    wire logic [PORT_A_PINS-1:0] next_dirA;
    wire logic [PORT_B_PINS-1:0] next_dirB;
    wire logic [PORT_C_PINS-1:0] next_dirC;
    wire logic [PORT_C_PINS-1:0] next_valueC;

    // Port C input synchroniser.
    logic [PORT_C_PINS-1:0] pinCMeta;
    logic [PORT_C_PINS-1:0] pinCSync;

    // Bus decode.
    gpio_regs_pkg::reg_sel_t regSel;
    wire logic [gpio_regs_pkg::ADDR_WIDTH-1:0] offset;
    wire logic              setupPhase;
    wire logic              accessPhase;
    wire logic              mapped;
    wire logic              lowLane;
    wire logic              writeLow;
    wire logic              wrDirA;
    wire logic              wrDirB;
    wire logic              wrDirC;
    wire logic              wrValueC;
    // Register selects, upper address check and read qualifier.
    wire logic              hitValueC;
    wire logic              hitDirA;
    wire logic              hitDirB;
    wire logic              hitDirC;
    wire logic              upperZero;
    wire logic              readSetup;

    // Read data and next pin states.
    logic [31:0]            readWord;
    wire logic [PORT_C_PINS-1:0] readValueC;
    wire logic [PORT_A_PINS-1:0] next_portAPinOeLow;
    wire logic [PORT_B_PINS-1:0] next_portBPinOeLow;
    wire logic [PORT_C_PINS-1:0] next_portCPinOeLow;
    wire logic [31:0]            readFieldA;
    wire logic [31:0]            readFieldB;
    wire logic [31:0]            readFieldC;
    wire logic [31:0]            readFieldValueC;
    wire logic [31:0]            next_prdata;

    // Reset release.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // Address decode and write strobes.
    assign offset      = paddr[gpio_regs_pkg::ADDR_WIDTH-1:0];
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign lowLane     = pstrb[0];

    always_comb begin
        unique case (offset)
            gpio_regs_pkg::PORT_C_PIN_VALUE_OFFSET:
                regSel = gpio_regs_pkg::REG_C_VALUE;
            gpio_regs_pkg::PORT_A_PIN_DIRECTION_OFFSET:
                regSel = gpio_regs_pkg::REG_A_DIRECTION;
            gpio_regs_pkg::PORT_B_PIN_DIRECTION_OFFSET:
                regSel = gpio_regs_pkg::REG_B_DIRECTION;
            gpio_regs_pkg::PORT_C_PIN_DIRECTION_OFFSET:
                regSel = gpio_regs_pkg::REG_C_DIRECTION;
            default:
                regSel = gpio_regs_pkg::REG_NONE;
        endcase
    end

    assign upperZero = (paddr[31:gpio_regs_pkg::ADDR_WIDTH] == 20'h00000);
    assign mapped    = (regSel != gpio_regs_pkg::REG_NONE) && upperZero;
    assign writeLow  = accessPhase && pwrite && mapped && lowLane;
    assign readSetup = setupPhase && !pwrite && mapped;

    // One select per register.
    assign hitValueC = (regSel == gpio_regs_pkg::REG_C_VALUE);
    assign hitDirA   = (regSel == gpio_regs_pkg::REG_A_DIRECTION);
    assign hitDirB   = (regSel == gpio_regs_pkg::REG_B_DIRECTION);
    assign hitDirC   = (regSel == gpio_regs_pkg::REG_C_DIRECTION);

    // Write strobes; all fields live in byte lane 0.
    assign wrDirA    = writeLow && hitDirA;
    assign wrDirB    = writeLow && hitDirB;
    assign wrDirC    = writeLow && hitDirC;
    assign wrValueC  = writeLow && hitValueC;

    // Write data trimmed to each field.
    assign next_dirA   = pwdata[PORT_A_PINS-1:0];
    assign next_dirB   = pwdata[PORT_B_PINS-1:0];
    assign next_dirC   = pwdata[PORT_C_PINS-1:0];
    assign next_valueC = pwdata[PORT_C_PINS-1:0];

    // The slave never waits; unmapped addresses answer with an error.
    assign pready  = 1'b1;
    assign pslverr = accessPhase && !mapped;

    // Port A direction register.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            dirA <= gpio_regs_pkg::PORT_A_DIRECTION_RESET;
        end else if (wrDirA) begin
            dirA <= next_dirA;
        end
    end

    // Port B direction register.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            dirB <= gpio_regs_pkg::PORT_B_DIRECTION_RESET;
        end else if (wrDirB) begin
            dirB <= next_dirB;
        end
    end

    // Port C direction register.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            dirC <= gpio_regs_pkg::PORT_C_DIRECTION_RESET;
        end else if (wrDirC) begin
            dirC <= next_dirC;
        end
    end

    // Port C data register.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            valueC <= gpio_regs_pkg::PORT_C_VALUE_RESET;
        end else if (wrValueC) begin
            valueC <= next_valueC;
        end
    end

    // Two-stage synchroniser on the port C pin levels.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pinCMeta <= '0;
            pinCSync <= '0;
        end else begin
            pinCMeta <= portCPinIn;
            pinCSync <= pinCMeta;
        end
    end

    // Per-pin enables and port C read selection.
    genvar i;
    generate
        for (i = 0; i < PORT_A_PINS; i++) begin : g_portA
            assign next_portAPinOeLow[i] =
                !(dirA[i] && !extBusDataSelect);
        end
        for (i = 0; i < PORT_B_PINS; i++) begin : g_portB
            assign next_portBPinOeLow[i] =
                !(dirB[i] && portBGpioSelect[i]);
        end
        for (i = 0; i < PORT_C_PINS; i++) begin : g_portC
            assign next_portCPinOeLow[i] = !dirC[i];
            assign readValueC[i] =
                dirC[i] ? valueC[i] : pinCSync[i];
        end
    endgenerate

    // Register fields widened to a bus word.
    assign readFieldA      = 32'(dirA);
    assign readFieldB      = 32'(dirB);
    assign readFieldC      = 32'(dirC);
    assign readFieldValueC = 32'(readValueC);

    // Read multiplexer; unused upper bits read as zero.
    always_comb begin
        readWord = 32'h00000000;
        unique case (regSel)
            gpio_regs_pkg::REG_C_VALUE:
                readWord = readFieldValueC;
            gpio_regs_pkg::REG_A_DIRECTION:
                readWord = readFieldA;
            gpio_regs_pkg::REG_B_DIRECTION:
                readWord = readFieldB;
            gpio_regs_pkg::REG_C_DIRECTION:
                readWord = readFieldC;
            gpio_regs_pkg::REG_NONE:
                readWord = 32'h00000000;
        endcase
    end

    // Read data is captured in the setup cycle and held through access.
    assign next_prdata = readSetup ? readWord : 32'h00000000;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            prdata <= 32'h00000000;
        end else if (setupPhase) begin
            prdata <= next_prdata;
        end
    end

    // Port A pin drivers; all pins float after reset.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            portAPinOut   <= '0;
            portAPinOeLow <= '1;
        end else begin
            portAPinOut   <= portAValue;
            portAPinOeLow <= next_portAPinOeLow;
        end
    end

    // Port B pin drivers; all pins float after reset.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            portBPinOut   <= '0;
            portBPinOeLow <= '1;
        end else begin
            portBPinOut   <= portBValue;
            portBPinOeLow <= next_portBPinOeLow;
        end
    end

    // Port C pin drivers; all pins float after reset.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            portCPinOut   <= '0;
            portCPinOeLow <= '1;
        end else begin
            portCPinOut   <= valueC;
            portCPinOeLow <= next_portCPinOeLow;
        end
    end

    assign portAPinDirection = dirA;
    assign portBPinDirection = dirB;
    assign portCPinDirection = dirC;

endmodule : gpio_direction_and_data_regs

// ==== gpio_regs_pkg.sv ====
// Constants shared by the GPIO direction and data register block.
package gpio_regs_pkg;

    // Register byte offsets on the register bus.
    localparam logic [11:0] PORT_C_PIN_VALUE_OFFSET     = 12'h000;
    localparam logic [11:0] PORT_A_PIN_DIRECTION_OFFSET = 12'h008;
    localparam logic [11:0] PORT_B_PIN_DIRECTION_OFFSET = 12'h00C;
    localparam logic [11:0] PORT_C_PIN_DIRECTION_OFFSET = 12'h010;

    // Address bits that form the register offset; the bits above must be zero.
    localparam int ADDR_WIDTH = 12;

    // Field widths; each field starts at bit 0.
    localparam int PORT_A_WIDTH = 8;
    localparam int PORT_B_WIDTH = 6;
    localparam int PORT_C_WIDTH = 8;
    localparam int FIELD_LSB    = 0;

    // Reset values of the registers.
    localparam logic [7:0] PORT_A_DIRECTION_RESET = 8'h00;
    localparam logic [5:0] PORT_B_DIRECTION_RESET = 6'h00;
    localparam logic [7:0] PORT_C_DIRECTION_RESET = 8'h00;
    localparam logic [7:0] PORT_C_VALUE_RESET     = 8'h00;

    // Stages of the input synchroniser and of the reset release.
    localparam int SYNC_STAGES = 2;

    // Register selected by a bus address.
    typedef enum logic [2:0] {
        REG_NONE,
        REG_C_VALUE,
        REG_A_DIRECTION,
        REG_B_DIRECTION,
        REG_C_DIRECTION
    } reg_sel_t;

endpackage : gpio_regs_pkg

// ==== gpio_regs_assertions.sv ====
// Checker for the GPIO direction and data register block.
module gpio_regs_checker #(
    parameter int PORT_A_PINS = 8,
    parameter int PORT_B_PINS = 6,
    parameter int PORT_C_PINS = 8
) (
    input wire logic                   clk,
    input wire logic                   rstn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic                   extBusDataSelect,
    input wire logic [31:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic [3:0]             pstrb,
    input wire logic [PORT_A_PINS-1:0] portAValue,
    input wire logic [PORT_A_PINS-1:0] portAPinOut,
    input wire logic [PORT_A_PINS-1:0] portAPinOeLow,
    input wire logic [PORT_A_PINS-1:0] portAPinDirection,
    input wire logic [PORT_B_PINS-1:0] portBGpioSelect,
    input wire logic [PORT_B_PINS-1:0] portBValue,
    input wire logic [PORT_B_PINS-1:0] portBPinOut,
    input wire logic [PORT_B_PINS-1:0] portBPinOeLow,
    input wire logic [PORT_B_PINS-1:0] portBPinDirection,
    input wire logic [PORT_C_PINS-1:0] portCPinOut,
    input wire logic [PORT_C_PINS-1:0] portCPinOeLow,
    input wire logic [PORT_C_PINS-1:0] portCPinDirection
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic rd = psel && penable && !pwrite;
    wire logic wr = psel && penable && pwrite && pstrb[0];
    a_porta_enable: assert property (portAPinOeLow ==
        (~$past(portAPinDirection) | {PORT_A_PINS{$past(extBusDataSelect)}}))
        else $error("Port A pin enable is wrong.");
    a_porta_level: assert property (
        (portAPinOut & ~portAPinOeLow) == ($past(portAValue) & ~portAPinOeLow))
        else $error("Port A level.");
    a_portb_level: assert property (
        (portBPinOut & ~portBPinOeLow) == ($past(portBValue) & ~portBPinOeLow))
        else $error("Port B level.");
    a_portb_enable: assert property (portBPinOeLow ==
        ~($past(portBPinDirection) & $past(portBGpioSelect)))
        else $error("Port B pin enable is wrong.");
    a_portc_enable: assert property (
        portCPinOeLow == ~$past(portCPinDirection)) else $error("Port C.");
    a_portc_level: assert property (
        (wr && paddr == 32'h0) |-> ##2
        portCPinOut == PORT_C_PINS'($past(pwdata, 2)))
        else $error("Port C output level wrong.");
    a_dira_write: assert property ((wr && paddr == 32'h8) |=>
        portAPinDirection == PORT_A_PINS'($past(pwdata)))
        else $error("Port A direction write lost.");
    a_dirb_write: assert property ((wr && paddr == 32'hC) |=>
        portBPinDirection == PORT_B_PINS'($past(pwdata)))
        else $error("Port B direction write lost.");
    a_reserved_zero: assert property (rd |-> prdata[31:8] == 24'h0)
        else $error("Reserved read bits set.");
    a_portb_reserved: assert property (
        (rd && paddr == 32'hC) |-> prdata[31:6] == 26'h0)
        else $error("Port B reserved bits set.");
    a_reset_clear: assert property ($rose(rstn) |->
        portAPinDirection == '0 && portBPinDirection == '0
        && portCPinOeLow == '1) else $error("Reset state wrong.");
endmodule : gpio_regs_checker

bind gpio_direction_and_data_regs gpio_regs_checker #(
    .PORT_A_PINS(PORT_A_PINS),
    .PORT_B_PINS(PORT_B_PINS),
    .PORT_C_PINS(PORT_C_PINS)
) watch_i (.*);

// ==== test_gpio_direction_and_data_regs.sv ====
// Self-checking bench for the GPIO direction and data register block.
module test_gpio_direction_and_data_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, extBusDataSelect = 1'b0, pready, pslverr;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'hF;
    logic [5:0]  portBGpioSelect = 6'h0, portBValue = 6'h0;
    logic [5:0]  portBPinOut, portBPinOeLow, portBPinDirection;
    logic [7:0]  portAValue = 8'h0, portAPinOut, portAPinOeLow;
    logic [7:0]  portCPinIn = 8'h0, portCPinOut, portCPinOeLow;
    logic [7:0]  portAPinDirection, portCPinDirection, d, v;
    logic [7:0]  seed = 8'h3D;
    logic [31:0] addrs[3] = '{32'h8, 32'hC, 32'h10};
    logic [7:0]  masks[3] = '{8'hFF, 8'h3F, 8'hFF};
    logic [32:0] expQ[$];
    logic [32:0] e;
    int          errCount = 0, cmpCount = 0;

    gpio_direction_and_data_regs dut (.*);

    initial forever #20 clk = ~clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic chk(input string n, input logic [31:0] x, y);
        cmpCount++;
        if (x !== y) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", n, x, y);
        end
    endtask : chk

    task automatic results;
        if (errCount == 0 && cmpCount > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // One APB transfer; the note holds the error flag and the data.
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [32:0] x);
        expQ.push_back(x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= x[31:0];
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer

    always @(posedge clk) begin
        if (rstn && psel && penable && pready) begin
            e = expQ.pop_front();
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
            if (!pwrite) chk("prdata", e[31:0], prdata);
        end
    end

    // Random pin-multiplexer selects and port A and B output values.
    always @(posedge clk) begin
        seed <= lfsr(seed);
        portAValue <= seed;
        portBValue <= seed[7:2];
        portBGpioSelect <= seed[5:0];
        extBusDataSelect <= seed[6];
    end

    initial begin
        repeat (10000) @(posedge clk);
        errCount++;
        results();
    end

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(1'b0, 32'h0, 33'h0);
        foreach (addrs[i]) xfer(1'b0, addrs[i], 33'h0);
        pstrb <= 4'hE;
        xfer(1'b1, 32'h8, 33'h0000000A5);
        pstrb <= 4'hF;
        xfer(1'b0, 32'h8, 33'h0);
        for (int k = 0; k < 6; k++) begin
            d = seed & masks[k % 3];
            xfer(1'b1, addrs[k % 3], {25'h0, d});
            xfer(1'b0, addrs[k % 3], {25'h0, d});
        end
        for (int k = 0; k < 4; k++) begin
            d = seed;
            v = lfsr(seed);
            xfer(1'b1, 32'h10, {25'h0, d});
            xfer(1'b1, 32'h0, {25'h0, v});
            portCPinIn <= ~v;
            xfer(1'b0, 32'h0, {25'h0, v & d | portCPinIn & ~d});
            xfer(1'b0, 32'h0, {25'h0, ~(v ^ d)});
            chk("portCPinOeLow", {24'h0, ~d}, {24'h0, portCPinOeLow});
            chk("portCPinOut", {24'h0, v}, {24'h0, portCPinOut});
        end
        xfer(1'b0, 32'h14, 33'h100000000);
        xfer(1'b1, 32'h1008, 33'h1000000FF);
        rstn <= 1'b0;
        portCPinIn <= 8'h00;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(1'b0, 32'h0, 33'h0);
        foreach (addrs[i]) xfer(1'b0, addrs[i], 33'h0);
        results();
    end
endmodule : test_gpio_direction_and_data_regs
